// >>> hw/mdr_pkg.sv
// Constants shared by the motor driver register bank
package mdr_pkg;
  localparam logic [6:0] MDR_DEV_ADDR = 7'h52;
  localparam logic [7:0] MDR_OFS_FAULT = 8'h00;
  localparam logic [7:0] MDR_OFS_SPEED = 8'h01;
  localparam logic [7:0] MDR_OFS_PERIOD = 8'h02;
  localparam logic [7:0] MDR_OFS_BEMF = 8'h03;
  localparam logic [7:0] MDR_OFS_CURRENT = 8'h04;
  localparam logic [7:0] MDR_OFS_POS_SUP = 8'h05;
  localparam logic [7:0] MDR_OFS_CMD_DUTY = 8'h06;
  localparam logic [7:0] MDR_OFS_ANALOG = 8'h07;
  localparam logic [7:0] MDR_OFS_ID = 8'h08;
  localparam logic [7:0] MDR_OFS_RW_BASE = 8'h30;
  localparam logic [7:0] MDR_OFS_CFG_BASE = 8'h90;
  localparam int MDR_RW_NUM = 7;
  localparam int MDR_CFG_NUM = 7;
  localparam logic [7:0] MDR_FAULT_CLEAR = 8'hff;
  localparam logic [15:0] MDR_FAULT_MASK = 16'hffbf;
  localparam logic [15:0] MDR_SPEED_CTRL_MASK = 16'h81ff;
  localparam int MDR_TAKEOVER_BIT = 15;
  localparam int MDR_KEY_IDX = 1;
  localparam logic [15:0] MDR_CFG_RESET [MDR_CFG_NUM] = '{
    16'hc000, 16'h0049, 16'h00c1, 16'h3788, 16'h3baf, 16'h7840, 16'h007a};
  localparam logic [7:0] MDR_DIE_CODE = 8'h5a; // Arbitrary value
  localparam logic [7:0] MDR_REV_CODE = 8'h01; // Arbitrary value
  typedef enum logic [1:0] {
    MDR_SRC_PWM = 2'b00,
    MDR_SRC_ANALOG = 2'b01,
    MDR_SRC_HOST = 2'b10,
    MDR_SRC_RSVD = 2'b11
  } mdr_src_e;
  typedef enum logic [2:0] {
    MDR_ST_IDLE = 3'b000,
    MDR_ST_ADDR = 3'b001,
    MDR_ST_REG = 3'b010,
    MDR_ST_WR = 3'b011,
    MDR_ST_ACK = 3'b100,
    MDR_ST_RD = 3'b101,
    MDR_ST_RDACK = 3'b110
  } mdr_state_e;
endpackage

// >>> hw/mdr_regbank.sv
// Two-wire slave register bank of the motor driver
`timescale 1ns/1ps
`default_nettype none
module mdr_regbank
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] fault_set,
  input wire logic [15:0] electrical_speed,
  input wire logic [15:0] electrical_period,
  input wire logic [15:0] bemf_constant,
  input wire logic [10:0] phase_current,
  input wire logic [7:0] initial_rotor_position,
  input wire logic [7:0] supply_level,
  input wire logic [1:0] speed_source_mode,
  input wire logic [7:0] input_pwm_duty,
  input wire logic [9:0] command_adc_sample,
  input wire logic [7:0] buffered_output_duty,
  output logic [15:0] fault_flags,
  output logic [7:0] speed_command_value,
  output logic [8:0] host_speed_setting,
  output logic host_speed_takeover,
  output logic [15:0] nvm_program_key,
  output logic [16*mdr_pkg::MDR_CFG_NUM-1:0] nvm_config
);
  import mdr_pkg::*;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  mdr_state_e state_reg;
  mdr_state_e after_ack_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic hi_byte_reg;
  logic [7:0] hi_data_reg;
  logic [7:0] lo_tx_reg;
  logic [7:0] tx_reg;
  logic master_ack_reg;
  logic wr_stb_reg;
  logic [15:0] wr_word_reg;
  logic fault_clr_reg;
  logic [15:0] fault_flags_reg;
  logic [7:0] speed_cmd_reg;
  logic [15:0] rw_reg [MDR_RW_NUM];
  logic [15:0] cfg_reg [MDR_CFG_NUM];
  logic [15:0] rd_word;
  logic [7:0] rw_idx;
  logic [7:0] cfg_idx;

  // Two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  // Bus events seen on the synchronised lines
  assign scl_rise = scl_sync_reg[1] & ~scl_d_reg;
  assign scl_fall = ~scl_sync_reg[1] & scl_d_reg;
  assign bus_start = scl_sync_reg[1] & scl_d_reg & sda_d_reg &
                     ~sda_sync_reg[1];
  assign bus_stop = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg &
                    sda_sync_reg[1];

  // Offsets relative to each writable bank; wrap-around falls out of range
  assign rw_idx = ptr_reg - MDR_OFS_RW_BASE;
  assign cfg_idx = ptr_reg - MDR_OFS_CFG_BASE;

  // Read mux; status inputs are read live at load time
  always_comb begin
    rd_word = 16'h0000;
    unique case (ptr_reg)
      MDR_OFS_FAULT: rd_word = fault_flags_reg;
      MDR_OFS_SPEED: rd_word = electrical_speed;
      MDR_OFS_PERIOD: rd_word = electrical_period;
      MDR_OFS_BEMF: rd_word = bemf_constant;
      MDR_OFS_CURRENT: rd_word = {5'h00, phase_current};
      MDR_OFS_POS_SUP: rd_word = {initial_rotor_position, supply_level};
      MDR_OFS_CMD_DUTY: begin
        rd_word = {speed_cmd_reg, buffered_output_duty};
      end
      MDR_OFS_ANALOG: rd_word = {6'h00, command_adc_sample};
      MDR_OFS_ID: rd_word = {MDR_DIE_CODE, MDR_REV_CODE};
      default: begin
        if (rw_idx < 8'(MDR_RW_NUM)) begin
          rd_word = rw_reg[rw_idx[2:0]];
        end else if (cfg_idx < 8'(MDR_CFG_NUM)) begin
          rd_word = cfg_reg[cfg_idx[2:0]];
        end
      end
    endcase
  end

  // Slave protocol engine; data changes only after SCL falls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= MDR_ST_IDLE;
      after_ack_reg <= MDR_ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      hi_byte_reg <= 1'b1;
      hi_data_reg <= 8'h00;
      lo_tx_reg <= 8'h00;
      tx_reg <= 8'h00;
      master_ack_reg <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_word_reg <= 16'h0000;
      fault_clr_reg <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      fault_clr_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= MDR_ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= MDR_ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state_reg)
          MDR_ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          MDR_ST_ADDR, MDR_ST_REG, MDR_ST_WR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              sda_oe <= 1'b1;
              state_reg <= MDR_ST_ACK;
              if (state_reg == MDR_ST_ADDR) begin
                hi_byte_reg <= 1'b1;
                after_ack_reg <= shift_reg[0] ? MDR_ST_RD : MDR_ST_REG;
                if (shift_reg[7:1] != MDR_DEV_ADDR) begin
                  sda_oe <= 1'b0;
                  state_reg <= MDR_ST_IDLE;
                end
              end else if (state_reg == MDR_ST_REG) begin
                ptr_reg <= shift_reg;
                hi_byte_reg <= 1'b1;
                after_ack_reg <= MDR_ST_WR;
              end else begin
                after_ack_reg <= MDR_ST_WR;
                hi_byte_reg <= ~hi_byte_reg;
                if (hi_byte_reg) begin
                  hi_data_reg <= shift_reg;
                  fault_clr_reg <= (ptr_reg == MDR_OFS_FAULT) &&
                                   (shift_reg == MDR_FAULT_CLEAR);
                end else begin
                  wr_stb_reg <= 1'b1;
                  wr_word_reg <= {hi_data_reg, shift_reg};
                end
              end
            end
          end
          MDR_ST_ACK: begin
            if (scl_fall) begin
              state_reg <= after_ack_reg;
              sda_oe <= 1'b0;
              if (after_ack_reg == MDR_ST_RD) begin
                // Word sampled here, so the two bytes always match
                tx_reg <= {rd_word[14:8], 1'b0};
                lo_tx_reg <= rd_word[7:0];
                sda_oe <= ~rd_word[15];
                hi_byte_reg <= 1'b0;
                bit_cnt_reg <= 4'h1;
              end
            end
          end
          MDR_ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                sda_oe <= 1'b0;
                bit_cnt_reg <= 4'h0;
                state_reg <= MDR_ST_RDACK;
              end else begin
                sda_oe <= ~tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          MDR_ST_RDACK: begin
            if (scl_rise) begin
              master_ack_reg <= ~sda_sync_reg[1];
            end else if (scl_fall) begin
              if (master_ack_reg) begin
                // Odd byte reloads the same full word, as the pointer never advances
                state_reg <= MDR_ST_RD;
                bit_cnt_reg <= 4'h1;
                hi_byte_reg <= ~hi_byte_reg;
                if (hi_byte_reg) begin
                  tx_reg <= {rd_word[14:8], 1'b0};
                  lo_tx_reg <= rd_word[7:0];
                  sda_oe <= ~rd_word[15];
                end else begin
                  tx_reg <= {lo_tx_reg[6:0], 1'b0};
                  sda_oe <= ~lo_tx_reg[7];
                end
              end else begin
                state_reg <= MDR_ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= MDR_ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain: only ever pulls low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Sticky faults; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_flags_reg <= 16'h0000;
    end else begin
      fault_flags_reg <= ((fault_clr_reg ? 16'h0000 : fault_flags_reg) |
                          fault_set) & MDR_FAULT_MASK;
    end
  end

  // Host registers; status offsets ignore writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MDR_RW_NUM; i++) begin
        rw_reg[i] <= 16'h0000;
      end
      for (int i = 0; i < MDR_CFG_NUM; i++) begin
        cfg_reg[i] <= MDR_CFG_RESET[i];
      end
    end else if (wr_stb_reg) begin
      if (rw_idx < 8'(MDR_RW_NUM)) begin
        rw_reg[rw_idx[2:0]] <= (rw_idx == 8'h00) ?
                               (wr_word_reg & MDR_SPEED_CTRL_MASK) :
                               wr_word_reg;
      end else if (cfg_idx < 8'(MDR_CFG_NUM)) begin
        cfg_reg[cfg_idx[2:0]] <= wr_word_reg;
      end
    end
  end

  // Speed command from the active source, 255 meaning full scale
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      speed_cmd_reg <= 8'h00;
    end else if (rw_reg[0][MDR_TAKEOVER_BIT]) begin
      speed_cmd_reg <= rw_reg[0][8:1];
    end else begin
      unique case (mdr_src_e'(speed_source_mode))
        MDR_SRC_PWM: speed_cmd_reg <= input_pwm_duty;
        MDR_SRC_ANALOG: speed_cmd_reg <= command_adc_sample[9:2];
        MDR_SRC_HOST: speed_cmd_reg <= rw_reg[0][8:1];
        MDR_SRC_RSVD: speed_cmd_reg <= 8'h00;
      endcase
    end
  end

  // Outputs taken straight from their flops; duty passes
  assign fault_flags = fault_flags_reg;
  assign speed_command_value = speed_cmd_reg;
  assign host_speed_setting = rw_reg[0][8:0];
  assign host_speed_takeover = rw_reg[0][MDR_TAKEOVER_BIT];
  assign nvm_program_key = rw_reg[MDR_KEY_IDX];
  genvar g;
  generate
    for (g = 0; g < MDR_CFG_NUM; g++) begin : g_cfg
      assign nvm_config[16*g +: 16] = cfg_reg[g];
    end
  endgenerate
endmodule
`default_nettype wire

// >>> verification/mdr_regbank_asserts.sv
// Pin-level checks for the motor driver register bank
`timescale 1ns/1ps
`default_nettype none
module mdr_regbank_asserts
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic [15:0] fault_set,
  input wire logic [15:0] fault_flags,
  input wire logic [1:0] speed_source_mode,
  input wire logic [7:0] input_pwm_duty,
  input wire logic [9:0] command_adc_sample,
  input wire logic [7:0] speed_command_value,
  input wire logic [8:0] host_speed_setting,
  input wire logic host_speed_takeover
);
  import mdr_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Source held two cycles, so the command flop has caught up
  sequence s_pwm;
    (speed_source_mode == MDR_SRC_PWM && !host_speed_takeover &&
      $stable(input_pwm_duty)) [*2];
  endsequence
  sequence s_adc;
    (speed_source_mode == MDR_SRC_ANALOG && !host_speed_takeover &&
      $stable(command_adc_sample)) [*2];
  endsequence
  sequence s_host;
    ((speed_source_mode == MDR_SRC_HOST || host_speed_takeover) &&
      $stable(host_speed_setting)) [*2];
  endsequence
  a_reset_clean: assert property ($fell(rst) |->
    !sda_oe && fault_flags == 16'h0) else $error("reset state wrong");
  a_pwm_cmd: assert property (s_pwm |->
    speed_command_value == input_pwm_duty) else $error("pwm command");
  a_adc_cmd: assert property (s_adc |->
    speed_command_value == command_adc_sample[9:2]) else $error("adc cmd");
  a_host_cmd: assert property (s_host |->
    speed_command_value == host_speed_setting[8:1]) else $error("host cmd");
  a_rsvd_cmd: assert property ((speed_source_mode == MDR_SRC_RSVD &&
    !host_speed_takeover) [*2] |-> speed_command_value == 8'h0)
    else $error("reserved source not zero");
  a_heat_latch: assert property (fault_set[15] |=>
    fault_flags[15]) else $error("heat flag not latched");
  a_stall_latch: assert property (fault_set[5] |=>
    fault_flags[5]) else $error("stall flag not latched");
  a_flag_sticky: assert property ($fell(fault_flags[0]) |->
    !$past(fault_set[0])) else $error("flag cleared while set");
  a_rsvd_flag: assert property (fault_flags[6] == 1'b0)
    else $error("reserved flag set");
  a_oe_steady: assert property ($changed(sda_oe) |-> !scl)
    else $error("data moved while clock high");
endmodule
bind mdr_regbank mdr_regbank_asserts u_asserts (
  .clk_sys(clk_sys),
  .rst(rst),
  .scl(scl),
  .sda_oe(sda_oe),
  .fault_set(fault_set),
  .fault_flags(fault_flags),
  .speed_source_mode(speed_source_mode),
  .input_pwm_duty(input_pwm_duty),
  .command_adc_sample(command_adc_sample),
  .speed_command_value(speed_command_value),
  .host_speed_setting(host_speed_setting),
  .host_speed_takeover(host_speed_takeover)
);
`default_nettype wire

// >>> verification/mdr_host.sv
// Two-wire host model driving the register bank's bus
`timescale 1ns/1ps
`default_nettype none
module mdr_host
(
  output logic scl,
  output logic pull_low,
  input wire logic sda_in
);
  import mdr_pkg::*;
  logic [6:0] dev = MDR_DEV_ADDR;
  logic ok;
  // Idle bus: clock stands high, data left to the pull-up
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic bit_tx(input logic b);
    #31.25 pull_low = ~b;
    #31.25 scl = 1'b1;
    #62.5 scl = 1'b0;
  endtask
  // Sample late in the high phase, device data long settled
  task automatic bit_rx(output logic b);
    #31.25 pull_low = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 b = sda_in;
    scl = 1'b0;
  endtask
  task automatic tx8(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bit_tx(d[i]);
    bit_rx(a);
    ok &= ~a;
  endtask
  task automatic rx8(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) bit_rx(d[i]);
    bit_tx(last);
  endtask
  // Long release before the rise: device may still hold its ack
  task automatic start;
    #31.25 pull_low = 1'b0;
    #62.5 scl = 1'b1;
    #62.5 pull_low = 1'b1;
    #62.5 scl = 1'b0;
  endtask
  task automatic stop;
    #31.25 pull_low = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 pull_low = 1'b0;
    #62.5;
  endtask
  task automatic head(input logic [7:0] a);
    ok = 1'b1;
    start();
    tx8({dev, 1'b0});
    tx8(a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    head(a);
    tx8(d[15:8]);
    tx8(d[7:0]);
    stop();
  endtask
  task automatic clr;
    head(MDR_OFS_FAULT);
    tx8(MDR_FAULT_CLEAR);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    head(a);
    start();
    tx8({dev, 1'b1});
    rx8(d[15:8], 1'b0);
    rx8(d[7:0], 1'b1);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> verification/mdr_regbank_test.sv
// Self-checking bench for the motor driver register bank
`timescale 1ns/1ps
`default_nettype none
module mdr_regbank_test;
  import mdr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic scl, pull_low, sda_out, sda_oe, host_speed_takeover;
  logic [15:0] fault_set = 16'h0, electrical_speed = 16'h1234;
  logic [15:0] electrical_period = 16'hbeef, bemf_constant = 16'h0f0f;
  logic [10:0] phase_current = 11'h5a5;
  logic [7:0] initial_rotor_position = 8'h2b, supply_level = 8'hc4;
  logic [7:0] input_pwm_duty = 8'he1, buffered_output_duty = 8'hff;
  logic [1:0] speed_source_mode = 2'h0;
  logic [9:0] command_adc_sample = 10'h2d7;
  logic [15:0] fault_flags, nvm_program_key, v;
  logic [7:0] speed_command_value;
  logic [8:0] host_speed_setting;
  logic [111:0] nvm_config;
  logic [7:0] cx [4] = '{8'he1, 8'hb5, 8'hff, 8'h00};
  logic [15:0] st [7] = '{16'h1234, 16'hbeef, 16'h0f0f, 16'h05a5,
    16'h2bc4, 16'he1ff, 16'h02d7};
  int bad_count = 0;
  int checked = 0;
  // Open drain, pulled up; the device drives its data level when enabled
  wire logic sda_in = (sda_oe ? sda_out : 1'b1) & ~pull_low;
  mdr_regbank dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .fault_set(fault_set),
    .electrical_speed(electrical_speed),
    .electrical_period(electrical_period),
    .bemf_constant(bemf_constant),
    .phase_current(phase_current),
    .initial_rotor_position(initial_rotor_position),
    .supply_level(supply_level),
    .speed_source_mode(speed_source_mode),
    .input_pwm_duty(input_pwm_duty),
    .command_adc_sample(command_adc_sample),
    .buffered_output_duty(buffered_output_duty),
    .fault_flags(fault_flags),
    .speed_command_value(speed_command_value),
    .host_speed_setting(host_speed_setting),
    .host_speed_takeover(host_speed_takeover),
    .nvm_program_key(nvm_program_key),
    .nvm_config(nvm_config)
  );
  mdr_host h (
    .scl(scl),
    .pull_low(pull_low),
    .sda_in(sda_in)
  );
  // System clock, 8 ns period
  initial forever #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    h.rd(a, v);
    chk({h.ok, v}, {1'b1, e});
  endtask
  task automatic wc(input logic [7:0] a, input logic [15:0] d,
    input logic [15:0] e);
    h.wr(a, d);
    rc(a, e);
  endtask
  task automatic summarize;
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence; inputs move on the falling edge
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({1'b1, nvm_config[15:0]}, {1'b1, 16'hc000});
    rc(8'h96, 16'h007a);
    rc(MDR_OFS_ID, {MDR_DIE_CODE, MDR_REV_CODE});
    wc(8'h30, 16'h8123, 16'h8123);
    chk({host_speed_takeover, 7'h0, host_speed_setting}, 17'h10123);
    rc(8'h06, 16'h91ff);
    wc(8'h30, 16'h7fff, 16'h01ff);
    wc(8'h31, 16'ha5c3, 16'ha5c3);
    chk({1'b1, nvm_program_key}, 17'h1a5c3);
    wc(8'h36, 16'h5aa5, 16'h5aa5);
    wc(8'h96, 16'h1234, 16'h1234);
    chk({1'b1, nvm_config[111:96]}, 17'h11234);
    for (int i = 1; i < 8; i++) rc(i[7:0], st[i-1]);
    wc(8'h01, 16'hffff, 16'h1234);
    @(negedge clk_sys) electrical_speed = 16'h4321;
    rc(8'h01, 16'h4321);
    // Every command source, full-scale codes included
    for (int m = 0; m < 4; m++) begin
      @(negedge clk_sys) speed_source_mode = m[1:0];
      rc(8'h06, {cx[m], 8'hff});
      chk({9'h0, speed_command_value}, {9'h0, cx[m]});
    end
    @(negedge clk_sys) buffered_output_duty = 8'h3c;
    rc(8'h06, 16'h003c);
    @(negedge clk_sys) fault_set = 16'hffff;
    @(negedge clk_sys) fault_set = 16'h0;
    chk({1'b1, fault_flags}, 17'h1ffbf);
    rc(8'h00, 16'hffbf);
    wc(8'h00, 16'h0000, 16'hffbf);
    h.clr();
    rc(8'h00, 16'h0000);
    h.dev = 7'h53;
    h.wr(8'h31, 16'h0000);
    chk({16'h0, h.ok}, 17'h0);
    h.dev = MDR_DEV_ADDR;
    rc(8'h31, 16'ha5c3);
    rc(8'h40, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
